// ---- rtl/pmt_pkg.sv ----
// constants, types and helpers shared by the period match timer
package pmt_pkg;

    // widths
    localparam int unsigned ADDR_W  = 16;
    localparam int unsigned DATA_W  = 32;
    localparam int unsigned REG_W   = 8;
    localparam int unsigned PRE_W   = 4;
    localparam int unsigned POST_W  = 4;
    localparam int unsigned IDX_W   = 12;

    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_CONTROL  = 12'h0fca;
    localparam logic [IDX_W-1:0] IDX_COUNT    = 12'h0fcb;
    localparam logic [IDX_W-1:0] IDX_PERIOD   = 12'h0fcc;
    localparam logic [IDX_W-1:0] IDX_REQUEST  = 12'h0fcd;
    localparam logic [IDX_W-1:0] IDX_ENABLE   = 12'h0fce;
    localparam logic [IDX_W-1:0] IDX_PRIORITY = 12'h0fcf;

    // reset values
    localparam logic [REG_W-1:0] COUNT_RST   = 8'h00;
    localparam logic [REG_W-1:0] PERIOD_RST  = 8'hff;
    localparam logic [REG_W-1:0] CONTROL_RST = 8'h00;

    // bit 7 of the control register is unimplemented
    localparam logic [REG_W-1:0] CTRL_WMASK  = 8'h7f;

    // match flag, enable and priority position in their registers
    localparam int unsigned IRQ_BIT = 1;

    // prescale_select codes
    localparam logic [1:0] PRE_DIV1  = 2'h0;
    localparam logic [1:0] PRE_DIV4  = 2'h1;
    localparam logic [1:0] PRE_DIV16 = 2'h2;

    // last prescale count mask for each ratio
    localparam logic [PRE_W-1:0] PRE_LAST1  = 4'h0;
    localparam logic [PRE_W-1:0] PRE_LAST4  = 4'h3;
    localparam logic [PRE_W-1:0] PRE_LAST16 = 4'hf;

    typedef struct packed {
        logic              rsvd;
        logic [POST_W-1:0] postscale_select;
        logic              timer_run;
        logic [1:0]        prescale_select;
    } pmt_ctrl_t;

    function automatic logic [ADDR_W-1:0] pmt_byte_addr(
        input logic [IDX_W-1:0] idx
    );
        pmt_byte_addr = {2'h0, idx, 2'h0};
    endfunction

    // code 11 falls back to sixteen
    function automatic logic [PRE_W-1:0] pmt_pre_last(
        input logic [1:0] sel
    );
        case (sel)
            PRE_DIV1: pmt_pre_last = PRE_LAST1;
            PRE_DIV4: pmt_pre_last = PRE_LAST4;
            default:  pmt_pre_last = PRE_LAST16;
        endcase
    endfunction

    // places a single flag at its bit in an otherwise zero byte
    function automatic logic [REG_W-1:0] pmt_bit_byte(input logic b);
        pmt_bit_byte          = '0;
        pmt_bit_byte[IRQ_BIT] = b;
    endfunction

endpackage

// ---- rtl/pmt_prescale.sv ----
// 4-bit prescale counter producing the count tick
`timescale 1ns/1ps
`default_nettype none
module pmt_prescale (
    input  wire logic       clk,   // instruction clock
    input  wire logic       rst,   // async reset, active high
    input  wire logic       ce,    // clock enable
    input  wire logic       clr,   // synchronous clear
    input  wire logic       run,   // timer running
    input  wire logic [1:0] sel,   // prescale_select
    output logic            tick   // one cycle count tick
);
    logic [pmt_pkg::PRE_W-1:0] cnt_q;
    logic [pmt_pkg::PRE_W-1:0] cnt_d;
    logic [pmt_pkg::PRE_W-1:0] last;

    assign last  = pmt_pkg::pmt_pre_last(sel);
    // tick on every 1st, 4th or 16th cycle of the free 4-bit count
    assign tick  = run & ((cnt_q & last) == last);
    assign cnt_d = clr ? '0 :
                   run ? pmt_pkg::PRE_W'(cnt_q + 4'h1) : cnt_q;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q <= '0;
        end
        else if (ce)
        begin
            cnt_q <= cnt_d;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/pmt_timer.sv ----
// period match timer with APB register access and match interrupt
//
// Functional notes
// - 8-bit count and 8-bit period registers
// - count rises from zero per prescaled tick
// - 4-bit prescaler offers ratios one, four, sixteen
// - prescale code 00/01/10 gives 1/4/16
// - count equals period gives the match signal
// - match zeroes count, steps postscale counter
// - postscale ratio is the code plus one
// - interrupt request comes from postscaled matches
// - flag, enable, priority sit at bit one
// - count and period readable, writable any time
// - reset clears count, period becomes all ones
// - count or control write, reset clear scalers
// - control write keeps the count value
// - timer_run bit two starts and stops counting
// - match output serves as serial shift clock
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pmt_timer (
    input  wire logic                        MCLK,     // instruction clock
    input  wire logic                        SYS_RST,  // async reset, high
    input  wire logic                        CE,       // clock enable
    input  wire logic                        PSEL,     // apb select
    input  wire logic                        PENABLE,  // apb access phase
    input  wire logic                        PWRITE,   // apb write
    input  wire logic [pmt_pkg::ADDR_W-1:0]  PADDR,    // apb byte address
    input  wire logic [pmt_pkg::DATA_W-1:0]  PWDATA,   // apb write data
    input  wire logic [3:0]                  PSTRB,    // apb byte strobes
    output logic      [pmt_pkg::DATA_W-1:0]  PRDATA,   // apb read data
    output logic                             PREADY,   // apb ready
    output logic                             PSLVERR,  // unmapped address
    output logic                             IRQ,      // match interrupt
    output logic                             IRQ_PRIO, // high priority
    output logic                             MATCH_OUT,// match pulse
    output logic                             SHIFT_CLK // serial shift clock
);
    localparam int unsigned RW = pmt_pkg::REG_W;
    localparam int unsigned PW = pmt_pkg::POST_W;

    // registers
    pmt_pkg::pmt_ctrl_t                ctrl_q;
    logic [RW-1:0]                     count_q;
    logic [RW-1:0]                     period_q;
    logic                              flag_q;
    logic                              enable_q;
    logic                              prio_q;
    logic [PW-1:0]                     post_q;
    logic                              irq_q;
    logic                              irq_prio_q;
    logic                              match_q;
    logic                              shift_q;
    logic                              pready_q;
    logic                              pslverr_q;
    logic [pmt_pkg::DATA_W-1:0]        prdata_q;

    // next values
    pmt_pkg::pmt_ctrl_t                ctrl_d;
    logic [RW-1:0]                     count_d;
    logic [RW-1:0]                     period_d;
    logic                              flag_d;
    logic                              enable_d;
    logic                              prio_d;
    logic [PW-1:0]                     post_d;

    // bus decode
    logic                              setup_ph;
    logic                              wr_fire;
    logic                              hit_ctrl;
    logic                              hit_count;
    logic                              hit_period;
    logic                              hit_req;
    logic                              hit_en;
    logic                              hit_prio;
    logic                              hit_any;
    logic                              wr_ctrl;
    logic                              wr_count;
    logic                              wr_period;
    logic                              wr_req;
    logic                              wr_en;
    logic                              wr_prio;
    logic [RW-1:0]                     wr_byte;
    logic                              wr_irq_bit;
    logic [RW-1:0]                     rd_byte;
    logic [pmt_pkg::DATA_W-1:0]        rd_word;

    // timer datapath
    logic                              tick;
    logic                              step;
    logic                              cnt_eq;
    logic                              match_ev;
    logic                              post_wrap;
    logic                              scaler_clr;

    // apb decode: one wait-free access phase after each setup
    assign setup_ph   = PSEL & ~PENABLE;
    assign wr_fire    = PSEL & PENABLE & pready_q & PWRITE & PSTRB[0];
    assign hit_ctrl   = PADDR == pmt_pkg::pmt_byte_addr(
                                     pmt_pkg::IDX_CONTROL);
    assign hit_count  = PADDR == pmt_pkg::pmt_byte_addr(
                                     pmt_pkg::IDX_COUNT);
    assign hit_period = PADDR == pmt_pkg::pmt_byte_addr(
                                     pmt_pkg::IDX_PERIOD);
    assign hit_req    = PADDR == pmt_pkg::pmt_byte_addr(
                                     pmt_pkg::IDX_REQUEST);
    assign hit_en     = PADDR == pmt_pkg::pmt_byte_addr(
                                     pmt_pkg::IDX_ENABLE);
    assign hit_prio   = PADDR == pmt_pkg::pmt_byte_addr(
                                     pmt_pkg::IDX_PRIORITY);
    assign hit_any    = hit_ctrl | hit_count | hit_period |
                        hit_req | hit_en | hit_prio;

    assign wr_ctrl    = wr_fire & hit_ctrl;
    assign wr_count   = wr_fire & hit_count;
    assign wr_period  = wr_fire & hit_period;
    assign wr_req     = wr_fire & hit_req;
    assign wr_en      = wr_fire & hit_en;
    assign wr_prio    = wr_fire & hit_prio;
    assign wr_byte    = PWDATA[RW-1:0];
    assign wr_irq_bit = PWDATA[pmt_pkg::IRQ_BIT];

    // read mux, upper bits read as zero
    assign rd_byte =
        hit_ctrl   ? ctrl_q :
        hit_count  ? count_q :
        hit_period ? period_q :
        hit_req    ? pmt_pkg::pmt_bit_byte(flag_q) :
        hit_en     ? pmt_pkg::pmt_bit_byte(enable_q) :
        hit_prio   ? pmt_pkg::pmt_bit_byte(prio_q) : '0;
    assign rd_word = {{(pmt_pkg::DATA_W - RW){1'b0}}, rd_byte};

    // prescaled tick of the instruction clock
    pmt_prescale u_prescale (
        .clk  (MCLK),
        .rst  (SYS_RST),
        .ce   (CE),
        .clr  (scaler_clr),
        .run  (ctrl_q.timer_run),
        .sel  (ctrl_q.prescale_select),
        .tick (tick)
    );

    // count write or control write restarts both scalers
    assign scaler_clr = wr_count | wr_ctrl;
    assign step       = ctrl_q.timer_run & tick;
    assign cnt_eq     = count_q == period_q;
    // a count or control write cancels a coincident match
    assign match_ev   = step & cnt_eq & ~scaler_clr;
    // selected ratio is code plus one matches
    assign post_wrap  = match_ev &
                        (post_q == ctrl_q.postscale_select);

    assign count_d =
        wr_count ? wr_byte :
        wr_ctrl  ? count_q :
        match_ev ? pmt_pkg::COUNT_RST :
        step     ? RW'(count_q + 8'h01) :
                   count_q;

    assign post_d =
        scaler_clr ? '0 :
        post_wrap  ? '0 :
        match_ev   ? PW'(post_q + 4'h1) :
                     post_q;

    assign period_d = wr_period ? wr_byte : period_q;
    assign ctrl_d   = wr_ctrl ?
                      pmt_pkg::pmt_ctrl_t'(wr_byte & pmt_pkg::CTRL_WMASK) :
                      ctrl_q;

    // set wins over a simultaneous write-one clear
    assign flag_d   = post_wrap |
                      (flag_q & ~(wr_req & wr_irq_bit));
    assign enable_d = wr_en   ? wr_irq_bit : enable_q;
    assign prio_d   = wr_prio ? wr_irq_bit : prio_q;

    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            count_q <= pmt_pkg::COUNT_RST;
        end
        else if (CE)
        begin
            count_q <= count_d;
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            period_q <= pmt_pkg::PERIOD_RST;
        end
        else if (CE)
        begin
            period_q <= period_d;
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            ctrl_q <= pmt_pkg::pmt_ctrl_t'(pmt_pkg::CONTROL_RST);
        end
        else if (CE)
        begin
            ctrl_q <= ctrl_d;
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            post_q <= '0;
        end
        else if (CE)
        begin
            post_q <= post_d;
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            flag_q <= 1'b0;
        end
        else if (CE)
        begin
            flag_q <= flag_d;
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            enable_q <= 1'b0;
        end
        else if (CE)
        begin
            enable_q <= enable_d;
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            prio_q <= 1'b0;
        end
        else if (CE)
        begin
            prio_q <= prio_d;
        end
    end

    // interrupt level follows the next flag and mask state
    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            irq_q <= 1'b0;
        end
        else if (CE)
        begin
            irq_q <= flag_d & enable_d;
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            irq_prio_q <= 1'b0;
        end
        else if (CE)
        begin
            irq_prio_q <= prio_d;
        end
    end

    // match pulse and half-rate shift clock for the serial port
    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            match_q <= 1'b0;
        end
        else if (CE)
        begin
            match_q <= match_ev;
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            shift_q <= 1'b0;
        end
        else if (CE)
        begin
            shift_q <= shift_q ^ match_ev;
        end
    end

    // apb answer: ready and data set up during the setup cycle
    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            pready_q <= 1'b0;
        end
        else if (CE)
        begin
            pready_q <= setup_ph;
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            pslverr_q <= 1'b0;
        end
        else if (CE)
        begin
            pslverr_q <= setup_ph & ~hit_any;
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            prdata_q <= '0;
        end
        else if (CE & setup_ph)
        begin
            prdata_q <= PWRITE ? '0 : rd_word;
        end
    end

    assign PRDATA    = prdata_q;
    assign PREADY    = pready_q;
    assign PSLVERR   = pslverr_q;
    assign IRQ       = irq_q;
    assign IRQ_PRIO  = irq_prio_q;
    assign MATCH_OUT = match_q;
    assign SHIFT_CLK = shift_q;
endmodule
`default_nettype wire

// ---- testbench/pmt_chk.sv ----
// assertions watching the period match timer ports
`timescale 1ns/1ps
`default_nettype none
module pmt_chk (
    input wire logic        MCLK,      // clock
    input wire logic        SYS_RST,   // reset
    input wire logic        CE,        // clock enable
    input wire logic        PSEL,      // select
    input wire logic        PENABLE,   // access phase
    input wire logic        PWRITE,    // write
    input wire logic [15:0] PADDR,     // address
    input wire logic [31:0] PWDATA,    // write data
    input wire logic [3:0]  PSTRB,     // strobes
    input wire logic [31:0] PRDATA,    // read data
    input wire logic        PREADY,    // ready
    input wire logic        PSLVERR,   // error
    input wire logic        IRQ,       // interrupt
    input wire logic        IRQ_PRIO,  // priority
    input wire logic        MATCH_OUT, // match pulse
    input wire logic        SHIFT_CLK  // shift clock
);
    wire wr_w  = PSEL && PENABLE && PREADY && PWRITE && PSTRB[0];
    wire clr_w = wr_w && PADDR == 16'h3f34 && PWDATA[1];
    wire ena_w = wr_w && PADDR == 16'h3f38;
    wire pri_w = wr_w && PADDR == 16'h3f3c;
    wire bit_w = PWDATA[1];
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (SYS_RST);
    a_ready_setup: assert property (PSEL && !PENABLE && CE |=> PREADY)
        else $error("no ready after setup");
    a_ready_access: assert property (PREADY |-> PSEL && PENABLE)
        else $error("ready outside access");
    a_ready_pulse: assert property (PREADY && CE |=> !PREADY)
        else $error("ready held");
    a_err_quiet: assert property (PSLVERR |-> PREADY && PRDATA == 0)
        else $error("error without ready or with data");
    a_upper_zero: assert property (PREADY |-> PRDATA[31:8] == 0)
        else $error("upper read bits set");
    a_shift_match: assert property ($past(CE) |->
        MATCH_OUT == (SHIFT_CLK != $past(SHIFT_CLK)))
        else $error("shift clock not tied to match");
    a_irq_clear: assert property (clr_w |=> !IRQ || MATCH_OUT)
        else $error("interrupt not cleared");
    a_irq_cause: assert property ($rose(IRQ) |-> MATCH_OUT || $past(ena_w))
        else $error("interrupt without cause");
    a_prio_copy: assert property (pri_w |=> IRQ_PRIO == $past(bit_w))
        else $error("priority output wrong");
    a_ce_freeze: assert property (!CE |=> $stable(MATCH_OUT) &&
        $stable(SHIFT_CLK) && $stable(IRQ) && $stable(PREADY))
        else $error("outputs moved while clock enable low");
endmodule
`default_nettype wire

// ---- testbench/tb_period_match_timer.sv ----
// self-checking bench for the period match timer
`timescale 1ns/1ps
`default_nettype none
module tb_period_match_timer;
    localparam logic [15:0] A_CTL = 16'h3f28;
    localparam logic [15:0] A_CNT = 16'h3f2c;
    localparam logic [15:0] A_PER = 16'h3f30;
    localparam logic [15:0] A_REQ = 16'h3f34;
    localparam logic [15:0] A_ENA = 16'h3f38;
    localparam logic [15:0] A_PRI = 16'h3f3c;
    logic        MCLK = 1'b0;
    logic        SYS_RST = 1'b1;
    logic        CE = 1'b1;
    logic        PSEL = 1'b0;
    logic        PENABLE = 1'b0;
    logic        PWRITE = 1'b0;
    logic [15:0] PADDR = '0;
    logic [31:0] PWDATA = '0;
    logic [3:0]  PSTRB = 4'hf;
    logic [31:0] PRDATA;
    logic        PREADY, PSLVERR, IRQ, IRQ_PRIO, MATCH_OUT, SHIFT_CLK;
    int          n_fail = 0;
    int          compares = 0;
    integer      seed = 32'h7d62;
    logic [32:0] q[$];
    logic [7:0]  v;
    logic [3:0]  p;
    logic        s0;
    int          n, t0, t1;

    always #5 MCLK = ~MCLK;

    pmt_timer dut (.MCLK(MCLK), .SYS_RST(SYS_RST), .CE(CE),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .IRQ(IRQ), .IRQ_PRIO(IRQ_PRIO),
        .MATCH_OUT(MATCH_OUT), .SHIFT_CLK(SHIFT_CLK));

    task automatic chk(input string nm, input logic [32:0] x,
                       input logic [32:0] g);
        compares++;
        if (x !== g)
        begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", nm, x, g);
        end
    endtask

    task automatic stop_test;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // one transfer; the expected answer is queued for the monitor
    task automatic apb(input logic w, input logic [15:0] a,
                       input logic [7:0] d, input logic [3:0] s,
                       input logic err, input logic [7:0] x);
        @(posedge MCLK);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= w;
        PADDR   <= a;
        PWDATA  <= {24'h00_0000, d};
        PSTRB   <= s;
        q.push_back({err, 24'h00_0000, x});
        @(posedge MCLK);
        PENABLE <= 1'b1;
        do
        begin
            @(posedge MCLK);
        end
        while (PREADY !== 1'b1);
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 4'hf, 1'b0, 8'h00);
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] x);
        apb(1'b0, a, 8'h00, 4'hf, 1'b0, x);
    endtask

    always @(posedge MCLK)
        if (PSEL && PENABLE && PREADY === 1'b1)
            chk("apb", q.pop_front(), {PSLVERR, PRDATA});

    initial
    begin
        #200000;
        n_fail++;
        stop_test();
    end

    initial
    begin
        repeat (8) @(posedge MCLK);
        SYS_RST <= 1'b0;
        rd(A_CNT, 8'h00);
        rd(A_PER, 8'hff);
        rd(A_CTL, 8'h00);
        apb(1'b0, 16'h3f40, 8'h00, 4'hf, 1'b1, 8'h00);
        apb(1'b1, 16'h3f29, 8'h55, 4'hf, 1'b1, 8'h00);
        v = 8'($random(seed));
        wr(A_PER, v);
        rd(A_PER, v);
        apb(1'b1, A_PER, ~v, 4'h0, 1'b0, 8'h00);
        rd(A_PER, v);
        wr(A_CTL, 8'hfb);
        rd(A_CTL, 8'h7b);
        wr(A_CTL, 8'h00);
        wr(A_CNT, 8'h05);
        repeat (20) @(posedge MCLK);
        rd(A_CNT, 8'h05);
        wr(A_PER, 8'hff);
        for (int c = 0; c < 4; c++)
        begin
            wr(A_CTL, 8'h00);
            wr(A_CNT, 8'h07);
            wr(A_CTL, {5'h00, 1'b1, 2'(c)});
            repeat (33) @(posedge MCLK);
            rd(A_CNT, 8'(7 + 34 / (c == 0 ? 1 : c == 1 ? 4 : 16)));
        end
        wr(A_CTL, 8'h00);
        wr(A_CNT, 8'h00);
        wr(A_CTL, 8'h04);
        repeat (4) @(posedge MCLK);
        CE <= 1'b0;
        repeat (10) @(posedge MCLK);
        CE <= 1'b1;
        rd(A_CNT, 8'h05);
        wr(A_ENA, 8'h02);
        for (int i = 0; i < 3; i++)
        begin
            p = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'($random(seed));
            wr(A_CTL, 8'h00);
            wr(A_PER, 8'h03);
            wr(A_CNT, 8'h00);
            wr(A_REQ, 8'h02);
            wr(A_CTL, {1'b0, p, 3'h4});
            s0 = SHIFT_CLK;
            n = 0;
            t0 = 0;
            t1 = 0;
            for (int k = 0; k < 400 && IRQ !== 1'b1; k++)
            begin
                @(posedge MCLK);
                if (MATCH_OUT === 1'b1)
                begin
                    if (n == 0)
                        t0 = k;
                    t1 = k;
                    n++;
                end
            end
            chk("matches", n, p + 1);
            chk("spacing", t1 - t0, p * 4);
            chk("shift", s0 ^ n[0], SHIFT_CLK);
            rd(A_REQ, 8'h02);
        end
        wr(A_CTL, 8'h00);
        wr(A_REQ, 8'h02);
        rd(A_REQ, 8'h00);
        chk("irq", 1'b0, IRQ);
        wr(A_ENA, 8'h00);
        wr(A_CTL, 8'h04);
        repeat (20) @(posedge MCLK);
        wr(A_CTL, 8'h00);
        rd(A_REQ, 8'h02);
        chk("irq", 1'b0, IRQ);
        wr(A_ENA, 8'h02);
        repeat (2) @(posedge MCLK);
        chk("irq", 1'b1, IRQ);
        wr(A_PRI, 8'h02);
        rd(A_PRI, 8'h02);
        repeat (2) @(posedge MCLK);
        chk("prio", 1'b1, IRQ_PRIO);
        wr(A_CNT, 8'h2a);
        SYS_RST <= 1'b1;
        repeat (2) @(posedge MCLK);
        SYS_RST <= 1'b0;
        rd(A_CNT, 8'h00);
        rd(A_PER, 8'hff);
        rd(A_PRI, 8'h00);
        chk("irq", 1'b0, IRQ);
        chk("prio", 1'b0, IRQ_PRIO);
        stop_test();
    end
endmodule

bind pmt_timer pmt_chk u_chk (.MCLK(MCLK), .SYS_RST(SYS_RST), .CE(CE),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .IRQ(IRQ), .IRQ_PRIO(IRQ_PRIO),
    .MATCH_OUT(MATCH_OUT), .SHIFT_CLK(SHIFT_CLK));
`default_nettype wire
